// *** rtl/arh_pkg.sv ***
package arh_pkg;

   localparam int CLOCK_KHZ       = 10000;
   localparam int PHASE1_US       = 800;
   localparam int PHASE2_US       = 3000;
   localparam int PHASE2_HPF_US   = 200000;
   localparam int PHASE1_CYC      = PHASE1_US * CLOCK_KHZ / 1000;
   localparam int PHASE2_CYC      = PHASE2_US * CLOCK_KHZ / 1000;
   localparam int PHASE2_HPF_CYC  = PHASE2_HPF_US * CLOCK_KHZ / 1000;
   localparam int CNT_W           = 32;

   localparam int CODE_W          = 10;
   localparam logic [9:0] CODE_MAX_LIN   = 10'h1fc;
   localparam logic [9:0] CODE_MIN_LIN   = 10'h203;
   localparam logic [9:0] CODE_OVERRANGE = 10'h1fd;
   localparam logic [9:0] CODE_OVERFLOW  = 10'h1fe;
   localparam logic [9:0] CODE_UNDERRNG  = 10'h202;
   localparam logic [9:0] CODE_UNDERFLOW = 10'h201;

   localparam logic [7:0] REG_CFG        = 8'h00;
   localparam logic [7:0] REG_STAT       = 8'h04;
   localparam logic [7:0] REG_AXIS1      = 8'h08;
   localparam logic [7:0] REG_AXIS2      = 8'h0c;
   localparam logic [7:0] REG_FUSE0      = 8'h10;
   localparam int FUSE_WORDS      = 4;
   localparam int FUSE_W          = 16;

   localparam int CFG_HPF_BIT     = 0;
   localparam int CFG_LPF1_LSB    = 1;
   localparam int CFG_LPF2_LSB    = 6;
   localparam int LPF_W           = 5;
   localparam logic [4:0] LPF_RESET = 5'h0c;

   localparam int STAT_INIT_BIT   = 0;
   localparam int STAT_TEST_BIT   = 1;
   localparam int STAT_PH2_BIT    = 2;
   localparam int DATA_CLASS_LSB  = 10;
   localparam int DATA_NOACC_BIT  = 15;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      CL_LINEAR, CL_OVERRANGE, CL_OVERFLOW, CL_UNDERRANGE, CL_UNDERFLOW
   } arh_class_t;

   typedef enum logic [2:0] {
      ST_POR, ST_FUSE_READ, ST_PHASE1, ST_PHASE2, ST_RUN
   } arh_state_t;

endpackage

// *** rtl/arh_axis_result.sv ***
`timescale 1ns/1ps
module arh_axis_result
   import arh_pkg::*;
#(
   parameter int DSP_W    = 16,
   parameter int SINC_MAX = 1000
) (
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    rstSyncN,
   // Filter output stream
   input  wire logic signed [DSP_W-1:0] sample,
   input  wire logic                    sampleValid,
   input  wire logic                    freezeSync,
   // Saturated path and serial buffer
   output logic signed [DSP_W-1:0]      satSample,
   output logic [CODE_W-1:0]            heldCode,
   output arh_class_t                   heldClass
);

   localparam logic signed [DSP_W-1:0] SAT_POS = DSP_W'(SINC_MAX);
   localparam logic signed [DSP_W-1:0] SAT_NEG = -DSP_W'(SINC_MAX);
   localparam logic signed [DSP_W-1:0] LIN_POS = DSP_W'(508);
   localparam logic signed [DSP_W-1:0] LIN_NEG = -DSP_W'(509);

   logic [CODE_W-1:0] next_code;
   arh_class_t        next_class;

   // Decided from the current sample alone, so clipping ends with the first in-range sample.
   always_comb begin
      next_code  = sample[CODE_W-1:0];
      next_class = CL_LINEAR;
      if (sample >= SAT_POS) begin
         next_code  = CODE_OVERFLOW;
         next_class = CL_OVERFLOW;
      end else if (sample > LIN_POS) begin
         next_code  = CODE_OVERRANGE;
         next_class = CL_OVERRANGE;
      end else if (sample <= SAT_NEG) begin
         next_code  = CODE_UNDERFLOW;
         next_class = CL_UNDERFLOW;
      end else if (sample < LIN_NEG) begin
         next_code  = CODE_UNDERRNG;
         next_class = CL_UNDERRANGE;
      end
   end

   // The processing path is never gated by the freeze input.
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         satSample <= '0;
      end else if (sampleValid) begin
         if (sample >= SAT_POS) begin
            satSample <= SAT_POS;
         end else if (sample <= SAT_NEG) begin
            satSample <= SAT_NEG;
         end else begin
            satSample <= sample;
         end
      end
   end

   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         heldCode  <= '0;
         heldClass <= CL_LINEAR;
      end else if (sampleValid && !freezeSync) begin
         heldCode  <= next_code;
         heldClass <= next_class;
      end
   end

endmodule // arh_axis_result

// *** rtl/arh_top.sv ***
`timescale 1ns/1ps
module arh_top
   import arh_pkg::*;
#(
   parameter int DSP_W          = 16,
   parameter int SINC_MAX       = 1000,
   parameter int PHASE1_CYCLES  = PHASE1_CYC,
   parameter int PHASE2_CYCLES  = PHASE2_CYC,
   parameter int PHASE2H_CYCLES = PHASE2_HPF_CYC
) (
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   // Supply monitors and mode qualifier
   input  wire logic                    vccAboveThr,
   input  wire logic                    digitalRegulatorRailOk,
   input  wire logic                    analogRegulatorRailOk,
   input  wire logic                    progVoltageHigh,
   // Filter outputs of both axes
   input  wire logic signed [DSP_W-1:0] axis1Sample,
   input  wire logic signed [DSP_W-1:0] axis2Sample,
   input  wire logic                    sampleValid,
   input  wire logic                    resultFreezeInput,
   // Fuse array
   output logic [1:0]                   fuseAddr,
   output logic                         fusePowerOn,
   input  wire logic [FUSE_W-1:0]       fuseData,
   // Analog front end control and filter selection
   output logic                         referenceEnable,
   output logic                         highpassInit,
   output logic                         highpassSelectBit,
   output logic [LPF_W-1:0]             lowpassOptionAxis1,
   output logic [LPF_W-1:0]             lowpassOptionAxis2,
   output logic                         initPendingFlag,
   output logic                         testMode,
   // AXI4-Lite write channels
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////////
   logic                    rstMeta;
   logic                    rstSyncN;
   logic                    freezeMeta;
   logic                    freezeSync;
   logic                    suppliesOk;
   arh_state_t              state;
   logic [CNT_W-1:0]        timer;
   logic [2:0]              fuseIdx;
   logic                    fuseCapture;
   logic [FUSE_W-1:0]       fuseMirror [FUSE_WORDS];
   logic                    accessOpen;
   logic                    accelReady;
   logic [31:0]             cfgWord;
   logic [DSP_W-1:0]        sat1;
   logic [DSP_W-1:0]        sat2;
   logic [CODE_W-1:0]       code1;
   logic [CODE_W-1:0]       code2;
   arh_class_t              class1;
   arh_class_t              class2;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   // Two stages so a buffer word is loaded whole or not at all.
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         freezeMeta <= 1'b0;
         freezeSync <= 1'b0;
      end else begin
         freezeMeta <= resultFreezeInput;
         freezeSync <= freezeMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign suppliesOk  = vccAboveThr && digitalRegulatorRailOk && analogRegulatorRailOk;
   assign accessOpen  = (state == ST_PHASE2) || (state == ST_RUN);
   assign accelReady  = (state == ST_RUN);
   assign fuseCapture = (state == ST_FUSE_READ) && (fuseIdx != 3'h0);

   // A supply dip at any time drops back to the power-on hold and restarts init.
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state <= ST_POR;
         timer <= '0;
      end else if (!suppliesOk) begin
         state <= ST_POR;
         timer <= '0;
      end else begin
         timer <= timer + 32'h1;
         case (state)
            ST_POR: begin
               state <= ST_FUSE_READ;
               timer <= '0;
            end
            ST_FUSE_READ: begin
               if (fuseIdx == 3'(FUSE_WORDS)) begin
                  state <= ST_PHASE1;
               end
            end
            ST_PHASE1: begin
               if (timer >= CNT_W'(PHASE1_CYCLES - 1)) begin
                  state <= ST_PHASE2;
                  timer <= '0;
               end
            end
            ST_PHASE2: begin
               if (highpassSelectBit ? (timer >= CNT_W'(PHASE2H_CYCLES - 1))
                                     : (timer >= CNT_W'(PHASE2_CYCLES - 1))) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               timer <= timer;
            end
            default: begin
               state <= ST_POR;
            end
         endcase
      end
   end

   // The address register lags the index by one cycle, so capture trails the index.
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         fuseIdx     <= '0;
         fuseAddr    <= '0;
         fusePowerOn <= 1'b0;
      end else if (state == ST_FUSE_READ && suppliesOk) begin
         fusePowerOn <= (fuseIdx != 3'(FUSE_WORDS));
         fuseIdx     <= fuseIdx + 3'h1;
         fuseAddr    <= fuseIdx[1:0];
      end else begin
         fuseIdx     <= '0;
         fuseAddr    <= '0;
         fusePowerOn <= (state == ST_POR) && suppliesOk;
      end
   end

   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         for (int i = 0; i < FUSE_WORDS; i++) begin
            fuseMirror[i] <= '0;
         end
      end else if (fuseCapture) begin
         fuseMirror[fuseIdx[1:0] - 2'h1] <= fuseData;
      end
   end

   // Mode is strapped each time the power-on hold ends, after reset or a supply dip; the supply level alone never selects it.
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         testMode <= 1'b0;
      end else if (state == ST_POR && suppliesOk) begin
         testMode <= progVoltageHigh;
      end
   end

   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         referenceEnable <= 1'b0;
         highpassInit    <= 1'b0;
         initPendingFlag <= 1'b1;
      end else begin
         referenceEnable <= (state == ST_PHASE2) || (state == ST_RUN);
         highpassInit    <= (state == ST_PHASE2) && highpassSelectBit;
         initPendingFlag <= (state != ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   arh_axis_result #(
      .DSP_W    (DSP_W),
      .SINC_MAX (SINC_MAX)
   ) u_axis1 (
      .clock       (clock),
      .rstSyncN    (rstSyncN),
      .sample      (axis1Sample),
      .sampleValid (sampleValid),
      .freezeSync  (freezeSync),
      .satSample   (sat1),
      .heldCode    (code1),
      .heldClass   (class1)
   );

   arh_axis_result #(
      .DSP_W    (DSP_W),
      .SINC_MAX (SINC_MAX)
   ) u_axis2 (
      .clock       (clock),
      .rstSyncN    (rstSyncN),
      .sample      (axis2Sample),
      .sampleValid (sampleValid),
      .freezeSync  (freezeSync),
      .satSample   (sat2),
      .heldCode    (code2),
      .heldClass   (class2)
   );

   ////////////////////////////////////////////////////////////////////////////////
   logic        awHeld;
   logic        wHeld;
   logic [7:0]  awAddr;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   logic        doWrite;

   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign cfgWord = {21'h0, lowpassOptionAxis2, lowpassOptionAxis1, highpassSelectBit};

   // Channels stall in phase one: the host sees no handshake at all.
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= '0;
         wData         <= '0;
         wStrb         <= '0;
      end else begin
         s_axi_awready <= accessOpen && !awHeld && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= accessOpen && !wHeld && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         highpassSelectBit  <= 1'b0;
         lowpassOptionAxis1 <= LPF_RESET;
         lowpassOptionAxis2 <= LPF_RESET;
      end else if (doWrite && awAddr[7:2] == REG_CFG[7:2]) begin
         if (wStrb[0]) begin
            highpassSelectBit  <= wData[CFG_HPF_BIT];
            lowpassOptionAxis1 <= wData[CFG_LPF1_LSB +: LPF_W];
         end
         if (wStrb[0] && wStrb[1]) begin
            lowpassOptionAxis2 <= wData[CFG_LPF2_LSB +: LPF_W];
         end
      end
   end

   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awAddr[7:2] == REG_CFG[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   // Before init completes the data words carry a marker bit instead of acceleration.
   always_comb begin
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      case (s_axi_araddr[7:2])
         REG_CFG[7:2]:   next_rdata = cfgWord;
         REG_STAT[7:2]:  next_rdata = {29'h0, (state == ST_PHASE2), testMode, initPendingFlag};
         REG_AXIS1[7:2]: next_rdata = accelReady ? {19'h0, class1, code1}
                                                 : 32'h0000_8000;
         REG_AXIS2[7:2]: next_rdata = accelReady ? {19'h0, class2, code2}
                                                 : 32'h0000_8000;
         default: begin
            if (s_axi_araddr[7:4] == REG_FUSE0[7:4]) begin
               next_rdata = {16'h0, fuseMirror[s_axi_araddr[3:2]]};
            end else begin
               next_rresp = RESP_SLVERR;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid && accessOpen) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // arh_top

// *** sim/arh_fuse_model.sv ***
`timescale 1ns/1ps
module arh_fuse_model
   import arh_pkg::*;
(
   // Fuse array port
   input  wire logic              clock,
   input  wire logic [1:0]        fuseAddr,
   input  wire logic              fusePowerOn,
   output logic [FUSE_W-1:0]      fuseData
);
   logic [FUSE_W-1:0] junk = 16'h0000;
   // Unpowered fuses give a changing pattern so a late sample cannot pass by luck.
   always_ff @(posedge clock) begin
      junk <= junk + 16'h1357;
   end
   assign fuseData = fusePowerOn ? {14'h1680, fuseAddr} : junk;
endmodule // arh_fuse_model

// *** sim/arh_asserts.sv ***
`timescale 1ns/1ps
module arh_checker (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        vccAboveThr,
   input wire logic        digitalRegulatorRailOk,
   input wire logic        analogRegulatorRailOk,
   input wire logic        fusePowerOn,
   input wire logic        referenceEnable,
   input wire logic        highpassInit,
   input wire logic        highpassSelectBit,
   input wire logic        initPendingFlag,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence s_supply_low;
      !(vccAboveThr && digitalRegulatorRailOk && analogRegulatorRailOk);
   endsequence
   sequence s_held_reset;
      initPendingFlag && !referenceEnable;
   endsequence
   a_supply_reset: assert property (s_supply_low |-> ##[1:3] s_held_reset)
      else $error("supply drop did not restart init");
   a_ref_no_fuse: assert property (referenceEnable |-> !fusePowerOn)
      else $error("fuses powered in phase two");
   a_hp_init: assert property (highpassInit |-> highpassSelectBit && referenceEnable)
      else $error("highpass init outside phase two");
   a_stall_phase1: assert property (!referenceEnable |-> !s_axi_awready && !s_axi_arready)
      else $error("bus accepted before phase two");
   a_pending_fall: assert property ($fell(initPendingFlag) |-> referenceEnable)
      else $error("pending cleared before phase two");
   a_done_ran: assert property (!initPendingFlag |-> referenceEnable && !highpassInit)
      else $error("init done without phase two");
   a_read_answer: assert property ($rose(s_axi_arready) |-> s_axi_rvalid)
      else $error("read accepted without answer");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule // arh_checker
bind arh_top arh_checker u_chk (.clock(clock), .arst_n(arst_n), .vccAboveThr(vccAboveThr),
   .digitalRegulatorRailOk(digitalRegulatorRailOk), .analogRegulatorRailOk(analogRegulatorRailOk),
   .fusePowerOn(fusePowerOn), .referenceEnable(referenceEnable), .highpassInit(highpassInit),
   .highpassSelectBit(highpassSelectBit), .initPendingFlag(initPendingFlag),
   .s_axi_awready(s_axi_awready), .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// *** sim/accel_result_hold_and_init_bench.sv ***
`timescale 1ns/1ps
module accel_result_hold_and_init_bench;
   import arh_pkg::*;
   logic clock, arst_n, vcc, dig, ana, pv, fuseOn, refEn, hpInit, hpSel, pend, tMode;
   logic aw, awr, wv, wr, bv, br, ar, arr, rv, rr, sv, frz;
   logic signed [15:0] s1, s2;
   logic [1:0] fa, bresp, rresp;
   logic [15:0] fd;
   logic [4:0] lp1, lp2;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd, got;
   int failures = 0, samples_checked = 0, ph2n = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Short phase counts keep the run brief; expectations use the same values.
   arh_top #(.PHASE1_CYCLES(20), .PHASE2_CYCLES(40), .PHASE2H_CYCLES(80)) u_dut (
      .clock(clock), .arst_n(arst_n), .vccAboveThr(vcc), .digitalRegulatorRailOk(dig),
      .analogRegulatorRailOk(ana), .progVoltageHigh(pv), .axis1Sample(s1),
      .axis2Sample(s2), .sampleValid(sv), .resultFreezeInput(frz), .fuseAddr(fa),
      .fusePowerOn(fuseOn), .fuseData(fd), .referenceEnable(refEn), .highpassInit(hpInit),
      .highpassSelectBit(hpSel), .lowpassOptionAxis1(lp1), .lowpassOptionAxis2(lp2),
      .initPendingFlag(pend), .testMode(tMode), .s_axi_awaddr(awa), .s_axi_awvalid(aw),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
   arh_fuse_model u_fuse (.clock(clock), .fuseAddr(fa), .fusePowerOn(fuseOn), .fuseData(fd));
   initial begin
      clock = 0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      if (!refEn) ph2n <= 0;
      else if (pend) ph2n <= ph2n + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit ta, tw, slow;
      ta = 0;
      tw = 0;
      slow = 1'($urandom_range(1));
      @(posedge clock);
      awa <= a; wd <= d; aw <= 1; wv <= 1;
      while (!(ta && tw)) begin
         @(posedge clock);
         if (aw && awr) begin ta = 1; aw <= 0; end
         if (wv && wr) begin tw = 1; wv <= 0; end
      end
      // A late bready makes the slave hold a pending response.
      br <= !slow;
      do @(posedge clock); while (!bv);
      while (!br) begin
         br <= 1;
         @(posedge clock);
      end
      r = bresp;
      br <= 0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit slow;
      slow = 1'($urandom_range(1));
      @(posedge clock);
      ara <= a;
      ar <= 1;
      rr <= !slow;
      do @(posedge clock); while (!arr);
      ar <= 0;
      while (!(rr && rv)) begin
         rr <= 1;
         @(posedge clock);
      end
      d = rd;
      r = rresp;
      rr <= 0;
   endtask
   function automatic logic [31:0] expw(input int s);
      int c, k;
      if (s >= 1000) begin c = 510; k = 2; end
      else if (s > 508) begin c = 509; k = 1; end
      else if (s <= -1000) begin c = -511; k = 4; end
      else if (s < -509) begin c = -510; k = 3; end
      else begin c = s; k = 0; end
      return {19'h0, k[2:0], c[9:0]};
   endfunction
   task automatic samp(input int a);
      s1 <= 16'(a);
      s2 <= 16'(-a);
      sv <= 1;
      @(posedge clock);
      sv <= 0;
      repeat (2) @(posedge clock);
   endtask
   task automatic chk_axes(input int a);
      logic [1:0] r;
      rd_reg(REG_AXIS1, got, r);
      chk("axis1", expw(a), got);
      rd_reg(REG_AXIS2, got, r);
      chk("axis2", expw(-a), got);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int tbl[10] = '{0, 508, 509, 999, 1000, 5, -509, -510, -1000, -3};
      logic [1:0] r;
      void'($urandom(32'h89a1));
      arst_n = 0; vcc = 1; dig = 1; ana = 1; pv = 0; frz = 0; sv = 0; s1 = 0; s2 = 0;
      aw = 0; wv = 0; br = 0; ar = 0; rr = 0; awa = 0; ara = 0; wd = 0;
      repeat (2) @(posedge clock);
      arst_n <= 1;
      @(posedge clock);
      chk("pending", 1, pend);
      chk("lpf reset", LPF_RESET, lp1);
      // No access is made before phase two, since phase one ignores the bus.
      wait (refEn === 1'b1);
      @(posedge clock);
      rd_reg(REG_AXIS1, got, r);
      chk("no accel", 32'h00008000, got);
      rd_reg(REG_STAT, got, r);
      chk("status ph2", 32'h5, got);
      wait (pend === 1'b0);
      chk("ph2 len", 1, ph2n >= 38 && ph2n <= 42);
      chk("normal mode", 0, tMode);
      @(posedge clock);
      rd_reg(REG_STAT, got, r);
      chk("status run", 0, got);
      for (int i = 0; i < FUSE_WORDS; i++) begin
         rd_reg(REG_FUSE0 + 8'(4 * i), got, r);
         chk("fuse", 32'h5a00 | i, got);
      end
      rd_reg(8'h40, got, r);
      chk("unmapped", RESP_SLVERR, r);
      wr_reg(REG_STAT, 32'h1, r);
      chk("ro write", RESP_SLVERR, r);
      for (int c = 0; c <= 18; c++) begin
         wr_reg(REG_CFG, {21'h0, 5'(18 - c), 5'(c), 1'b0}, r);
         chk("lpf1", c, lp1);
         chk("lpf2", 18 - c, lp2);
      end
      foreach (tbl[i]) begin
         samp(tbl[i]);
         chk_axes(tbl[i]);
      end
      repeat (40) begin
         int v;
         v = int'($urandom_range(2400)) - 1200;
         samp(v);
         chk_axes(v);
      end
      samp(100);
      frz <= 1;
      repeat (3) @(posedge clock);
      samp(1000);
      chk_axes(100);
      frz <= 0;
      repeat (3) @(posedge clock);
      samp(-700);
      chk_axes(-700);
      // The qualifier is raised while supplies are low, so the restart straps test mode.
      vcc <= 0;
      pv <= 1;
      repeat (4) @(posedge clock);
      chk("drop pend", 1, pend);
      chk("drop ref", 0, refEn);
      vcc <= 1;
      wait (refEn === 1'b1);
      chk("test mode", 1, tMode);
      @(posedge clock);
      wr_reg(REG_CFG, 32'h1, r);
      @(posedge clock);
      chk("hpf init", 1, hpInit);
      chk("hpf sel", 1, hpSel);
      wait (pend === 1'b0);
      chk("ph2 hpf", 1, ph2n >= 77 && ph2n <= 83);
      end_of_test();
   end
endmodule // accel_result_hold_and_init_bench
